// file: dv/dct_pin_model.sv
// Far-side model: capture sources on both pins and the slow clock
`timescale 1ns/10ps
module dct_pin_model (
  input  wire logic clk,
  input  wire logic want_a,
  input  wire logic want_b,
  input  wire logic slow_on,
  output logic      pin_a,
  output logic      pin_b,
  output logic      slow_clk
);
  logic [2:0] div_reg = 3'h0;

  // Levels change only at clock edges, so each lasts a full cycle
  always @(posedge clk) begin
    pin_a <= want_a;
    pin_b <= want_b;
    div_reg <= slow_on ? div_reg + 3'h1 : 3'h0;
  end
  // Eighth of the system rate keeps inside the synchroniser's limit
  assign slow_clk = div_reg[2];
endmodule

// file: dv/dct_timer_properties.sv
// Port-level assertions for the dual counter capture timer
`timescale 1ns/10ps
module dct_timer_properties #(
  parameter int ADDR_W = 6
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              pin_a_in,
  input wire logic              pin_a_out,
  input wire logic              pin_a_oe,
  input wire logic              pin_b_in,
  input wire logic              slow_clk_in,
  input wire logic              irq_line_one,
  input wire logic              irq_line_two
);
  // One clock domain, so one clock and reset serve every check
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Bus handshakes: answers come within fixed bounds and then retire
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write answer missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer missing");
  a_write_retire: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("write answer repeated");
  a_read_retire: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid && s_axi_arready) else $error("read not retired");
  // Nothing new is taken while an answer is pending
  a_write_block: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write overlap");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read overlap");
  a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[5:0] > 6'h20 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 0)
    else $error("unmapped read not refused");
  a_reset_quiet: assert property (
    $fell(rst) |-> !irq_line_one && !irq_line_two && !pin_a_oe)
    else $error("outputs active after reset");
endmodule

bind dct_timer dct_timer_properties #(.ADDR_W(ADDR_W)) u_props (
  .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pin_a_in(pin_a_in), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
  .pin_b_in(pin_b_in), .slow_clk_in(slow_clk_in),
  .irq_line_one(irq_line_one), .irq_line_two(irq_line_two)
);

// file: dv/dct_timer_tb.sv
// Self-checking bench for the dual counter capture timer
`timescale 1ns/10ps
`include "dct_defines.svh"
module dct_timer_tb;
  import dct_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  aw, ar;
  logic [31:0] wd, rdat, v;
  logic [1:0]  bresp, rresp, r;
  logic        awv, wv, arv, awr, wr_rdy, bv, arr, rv;
  logic        want_a, want_b, slow_on, pa, pb, sclk;
  logic        pout, poe, irq1, irq2;
  int          err_count, total_checks, cycles, n, m;

  always #20 clk = ~clk;

  dct_timer uut (.clk(clk), .rst(rst), .s_axi_awaddr(aw),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1), .pin_a_in(pa), .pin_a_out(pout),
    .pin_a_oe(poe), .pin_b_in(pb), .slow_clk_in(sclk),
    .irq_line_one(irq1), .irq_line_two(irq2));

  dct_pin_model u_pins (.clk(clk), .want_a(want_a), .want_b(want_b),
    .slow_on(slow_on), .pin_a(pa), .pin_b(pb), .slow_clk(sclk));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task wr(input logic [5:0] a, input logic [15:0] d);
    aw <= a;
    wd <= {16'h0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (!bv);
    r = bresp;
  endtask

  task rd(input logic [5:0] a);
    ar <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    v = rdat;
    r = rresp;
  endtask

  // Pulse one pin high for two cycles, then let the edge settle
  task pulse(input logic on_b);
    if (on_b) want_b <= 1'b1;
    else want_a <= 1'b1;
    repeat (2) @(posedge clk);
    want_a <= 1'b0;
    want_b <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Cycles until the output pin next changes; calls in a row see
  // consecutive intervals, so the first call only aligns
  task gap(output int c);
    logic p;
    p = pout;
    c = 0;
    while (pout === p) begin
      @(posedge clk);
      c++;
    end
  endtask

  task test_done;
    if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard: the sequence needs only a few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("mismatch at %0t: timeout", $time);
      test_done();
    end
  end

  initial begin
    {awv, wv, arv, want_a, want_b, slow_on} = '0;
    aw = 6'h00;
    ar = 6'h00;
    wd = 32'h0000_0000;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Control state after reset, then unmapped accesses
    rd(`DCT_OFF_CLOCK_UNIT); chk(v, 32'h0000_0000);
    rd(`DCT_OFF_MODE_CTRL); chk(v, 32'h0000_0000);
    rd(`DCT_OFF_INT_CTRL); chk(v, 32'h0000_0000);
    rd(6'h24); chk(r, 2'h2);
    wr(6'h28, 16'h0001); chk(r, 2'h2);
    // Pending flags: set by software, zero ignored, clear by register
    wr(`DCT_OFF_INT_CTRL, 16'h000F);
    wr(`DCT_OFF_INT_CTRL, 16'h0000);
    rd(`DCT_OFF_INT_CTRL); chk(v, 32'h0000_000F);
    chk({irq1, irq2}, 2'b00);
    wr(`DCT_OFF_INT_CTRL, 16'h0080);
    repeat (2) @(posedge clk);
    chk({irq1, irq2}, 2'b01);
    wr(`DCT_OFF_INT_CTRL, 16'h00F0);
    repeat (2) @(posedge clk);
    chk(irq1, 1'b1);
    wr(`DCT_OFF_PEND_CLEAR, 16'h0007);
    repeat (2) @(posedge clk);
    chk({irq1, irq2}, 2'b01);
    wr(`DCT_OFF_PEND_CLEAR, 16'h0008);
    rd(`DCT_OFF_INT_CTRL); chk(v, 32'h0000_00F0);
    // Mode 3: square wave on pin A from a start level of one
    wr(`DCT_OFF_PRESCALER, 16'h0000);
    wr(`DCT_OFF_RELOAD_A, 16'h0003);
    wr(`DCT_OFF_PRIMARY, 16'h0003);
    wr(`DCT_OFF_MODE_CTRL, 16'h0052);
    @(posedge clk);
    chk({pout, poe}, 2'b11);
    wr(`DCT_OFF_CLOCK_UNIT, 16'h0001);
    gap(n);
    gap(n); chk(n, 4);
    gap(n); chk(n, 4);
    wr(`DCT_OFF_CLOCK_UNIT, 16'h0000);
    rd(`DCT_OFF_INT_CTRL); chk(v[2:0], 3'h1);
    wr(`DCT_OFF_PEND_CLEAR, 16'h000F);
    // Mode 3 secondary: reload from B raises line two
    wr(`DCT_OFF_SECONDARY, 16'h0002);
    wr(`DCT_OFF_RELOAD_B, 16'h0002);
    wr(`DCT_OFF_CLOCK_UNIT, 16'h0008);
    repeat (10) @(posedge clk);
    wr(`DCT_OFF_CLOCK_UNIT, 16'h0000);
    rd(`DCT_OFF_INT_CTRL); chk(v[3:0], 4'h8);
    chk(irq2, 1'b1);
    wr(`DCT_OFF_PEND_CLEAR, 16'h000F);
    // Mode 3: rising pin B events clock the secondary counter
    wr(`DCT_OFF_SECONDARY, 16'h0064);
    wr(`DCT_OFF_MODE_CTRL, 16'h000A);
    wr(`DCT_OFF_CLOCK_UNIT, 16'h0010);
    repeat (3) pulse(1'b1);
    // Accumulate: two prescaler ticks while pin B stands high
    wr(`DCT_OFF_CLOCK_UNIT, 16'h0018);
    pulse(1'b1);
    wr(`DCT_OFF_CLOCK_UNIT, 16'h0000);
    rd(`DCT_OFF_SECONDARY); chk(v, 32'h0000_005F);
    // Mode 4: capture with preset while the secondary keeps running
    wr(`DCT_OFF_PRESCALER, 16'h001F);
    wr(`DCT_OFF_SECONDARY, 16'h1000);
    wr(`DCT_OFF_MODE_CTRL, 16'h002B);
    wr(`DCT_OFF_CLOCK_UNIT, 16'h0008);
    pulse(1'b1);
    rd(`DCT_OFF_RELOAD_B); chk(v <= 32'h1000 && v >= 32'h0FF0, 1);
    rd(`DCT_OFF_SECONDARY); chk(v[15:4], 12'hFFF);
    rd(`DCT_OFF_INT_CTRL); chk(v[1], 1'b1);
    // Mode 4: event select is refused, capture still works unpreset
    wr(`DCT_OFF_MODE_CTRL, 16'h000B);
    wr(`DCT_OFF_CLOCK_UNIT, 16'h0010);
    wr(`DCT_OFF_SECONDARY, 16'h0032);
    repeat (2) pulse(1'b1);
    rd(`DCT_OFF_SECONDARY); chk(v, 32'h0000_0032);
    rd(`DCT_OFF_RELOAD_B); chk(v, 32'h0000_0032);
    // Mode 2: pin A captures the primary and presets it
    wr(`DCT_OFF_CLOCK_UNIT, 16'h0000);
    wr(`DCT_OFF_PEND_CLEAR, 16'h000F);
    wr(`DCT_OFF_PRIMARY, 16'h0020);
    wr(`DCT_OFF_MODE_CTRL, 16'h0015);
    pulse(1'b0);
    chk(poe, 1'b0);
    rd(`DCT_OFF_RELOAD_A); chk(v, 32'h0000_0020);
    rd(`DCT_OFF_PRIMARY); chk(v, 32'h0000_FFFF);
    rd(`DCT_OFF_INT_CTRL); chk(v[3:0], 4'h1);
    // Mode 1: reloads alternate between A and B
    wr(`DCT_OFF_PEND_CLEAR, 16'h000F);
    wr(`DCT_OFF_PRESCALER, 16'h0000);
    wr(`DCT_OFF_RELOAD_A, 16'h0001);
    wr(`DCT_OFF_RELOAD_B, 16'h0002);
    wr(`DCT_OFF_MODE_CTRL, 16'h0010);
    wr(`DCT_OFF_PRIMARY, 16'h0000);
    wr(`DCT_OFF_CLOCK_UNIT, 16'h0001);
    gap(n);
    gap(n);
    gap(m);
    chk(n + m, 5);
    wr(`DCT_OFF_CLOCK_UNIT, 16'h0000);
    rd(`DCT_OFF_INT_CTRL); chk(v[2:0], 3'h3);
    // Slow clock at an eighth of the rate: nine to twelve ticks
    slow_on <= 1'b1;
    wr(`DCT_OFF_PRIMARY, 16'h0040);
    wr(`DCT_OFF_CLOCK_UNIT, 16'h0004);
    repeat (80) @(posedge clk);
    rd(`DCT_OFF_PRIMARY);
    chk(v >= 32'h0000_0034 && v <= 32'h0000_0037, 1);
    test_done();
  end
endmodule

// file: include/dct_defines.svh
// Register map, field positions, codes and constant values of the dual timer
`ifndef DCT_DEFINES_SVH
`define DCT_DEFINES_SVH

// Byte offsets on the register bus
`define DCT_OFF_PRESCALER   6'h00
`define DCT_OFF_CLOCK_UNIT  6'h04
`define DCT_OFF_PRIMARY     6'h08
`define DCT_OFF_SECONDARY   6'h0C
`define DCT_OFF_RELOAD_A    6'h10
`define DCT_OFF_RELOAD_B    6'h14
`define DCT_OFF_MODE_CTRL   6'h18
`define DCT_OFF_INT_CTRL    6'h1C
`define DCT_OFF_PEND_CLEAR  6'h20

// Clock unit fields
`define DCT_CLK1_LSB        0
`define DCT_CLK2_LSB        3
// Mode control fields
`define DCT_MODE_LSB        0
`define DCT_A_EDGE_BIT      2
`define DCT_B_EDGE_BIT      3
`define DCT_A_EN_BIT        4
`define DCT_B_EN_BIT        5
`define DCT_A_LEVEL_BIT     6
// Interrupt control fields
`define DCT_PEND_LSB        0
`define DCT_IEN_LSB         4
// Source indices within the pending and enable nibbles
`define DCT_SRC_A           0
`define DCT_SRC_B           1
`define DCT_SRC_C           2
`define DCT_SRC_D           3

// Values
`define DCT_PRESET          16'hFFFF
`define DCT_ZERO16          16'h0000
`define DCT_ONE16           16'h0001
`define DCT_PSC_ONE         5'h01
`define DCT_ZERO32          32'h0000_0000
`define DCT_RESP_OKAY       2'h0
`define DCT_RESP_SLVERR     2'h2

// System request lines of the two timer units
`define DCT_UNIT1_LINE1_IRQ 13
`define DCT_UNIT1_LINE2_IRQ 12
`define DCT_UNIT2_LINE1_IRQ 11
`define DCT_UNIT2_LINE2_IRQ 10

`endif

// file: include/dct_pkg.sv
// Types shared by the dual counter capture timer
package dct_pkg;

  // Operating modes in field-code order
  typedef enum logic [1:0] {
    DCT_MODE_PWM,
    DCT_MODE_CAPTURE,
    DCT_MODE_DUAL,
    DCT_MODE_SINGLE
  } dct_mode_e;

  // Counter clock sources in field-code order; codes above are undefined
  typedef enum logic [2:0] {
    DCT_CLK_STOP,
    DCT_CLK_PRESC,
    DCT_CLK_EVENT,
    DCT_CLK_ACCUM,
    DCT_CLK_SLOW
  } dct_clk_e;

  // Control and bus state, cleared by reset
  typedef struct packed {
    logic [4:0]  presc;
    logic [4:0]  psc_cnt;
    logic [2:0]  clk1;
    logic [2:0]  clk2;
    logic [1:0]  mode;
    logic        a_edge;
    logic        b_edge;
    logic        a_en;
    logic        b_en;
    logic        a_level;
    logic [3:0]  pend;
    logic [3:0]  ien;
    logic        pwm_sel;
    logic        pin_a_prev;
    logic        pin_b_prev;
    logic        slow_s1;
    logic        slow_s2;
    logic        slow_s3;
    logic        irq1;
    logic        irq2;
    logic        pin_a_oe;
    logic        awready;
    logic        wready;
    logic        aw_have;
    logic [5:0]  awaddr;
    logic        w_have;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } dct_ctl_s;

  // Count and reload state, left alone by reset
  typedef struct packed {
    logic [15:0] cnt1;
    logic [15:0] cnt2;
    logic [15:0] cra;
    logic [15:0] crb;
  } dct_dat_s;

endpackage

// file: src/dct_timer.sv
// Dual counter capture timer unit with an AXI4-Lite register slave
`timescale 1ns/10ps
`include "dct_defines.svh"

// Operation
// - Modes 3 and 4: primary counts down per tick, reloads from reload A.
// - Modes 1, 3, 4 with pin A enabled: pin A toggles per primary underflow.
// - Toggling pin A starts from the level bit; software sets it first.
// - Modes 3, 4: primary reload sets source A; source C stays unused.
// - Mode 3: secondary counts down, reloads from reload B on underflow.
// - Mode 3: secondary underflow sets flag D; enable D gates interrupt.
// - Mode 3: pin B event, accumulate or prescaled clock drive counters.
// - Mode 4: chosen pin B edge copies secondary count into reload B.
// - Preset capture stores count first, then loads counter with all ones.
// - Mode 4: pin B capture sets flag B; secondary underflow sets flag D.
// - Modes 2, 4: event or accumulate clock select stops that counter.
// - Four sources A-D; A, B, C feed line one, D feeds line two.
// - Unit one lines go to requests 13 and 12, unit two to 11 and 10.
// - Mode 1: A reload from A, B reload from B, D secondary underflow.
// - Mode 2: A pin A capture, B pin B capture, C and D underflows.
// - Modes 3, 4 source A on reload; mode 3 D on secondary reload.
// - Mode 2 pin A captures primary, presets when enabled; else no output.
// - Pin B is clock input in modes 1, 3; capture pin in modes 2, 4.
// - Mode field: 00 PWM, 01 dual capture, 10 dual counter, 11 single.
// - Clock select: 000 stop, 001 prescaled, 010 event, 011 accum, 100 slow.
// - Pending set by hardware or software; cleared only via clear register.
// - Hardware updates pin A level; a same-cycle software write wins.
module dct_timer #(
  parameter int ADDR_W = 6
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              pin_a_in,
  output logic                   pin_a_out,
  output logic                   pin_a_oe,
  input  wire logic              pin_b_in,
  input  wire logic              slow_clk_in,
  output logic                   irq_line_one,
  output logic                   irq_line_two
);
  import dct_pkg::*;

  // The map needs six address bits; wider buses decode only those
  if (ADDR_W < 6) begin : g_addr_check
    $error("dct_timer: ADDR_W must be at least 6");
  end

  dct_ctl_s c_reg;
  dct_ctl_s c_next;
  dct_dat_s d_reg;
  dct_dat_s d_next;

  // Tick for one counter from its clock select
  function automatic logic clk_tick(input logic [2:0] sel,
                                    input logic       capt,
                                    input logic       tp,
                                    input logic       ev,
                                    input logic       acc,
                                    input logic       slow);
    logic t;
    t = 1'b0;
    case (sel)
      DCT_CLK_STOP:  t = 1'b0;
      DCT_CLK_PRESC: t = tp;
      DCT_CLK_EVENT: t = !capt && ev;
      DCT_CLK_ACCUM: t = !capt && tp && acc;
      DCT_CLK_SLOW:  t = slow;
      default:       t = 1'b0;
    endcase
    return t;
  endfunction

  // Byte-lane merge of a bus write into a register word
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Whether a byte offset names a register
  function automatic logic addr_hit(input logic [5:0] a);
    logic h;
    h = 1'b0;
    case (a)
      `DCT_OFF_PRESCALER, `DCT_OFF_CLOCK_UNIT, `DCT_OFF_PRIMARY,
      `DCT_OFF_SECONDARY, `DCT_OFF_RELOAD_A, `DCT_OFF_RELOAD_B,
      `DCT_OFF_MODE_CTRL, `DCT_OFF_INT_CTRL, `DCT_OFF_PEND_CLEAR: h = 1'b1;
      default: h = 1'b0;
    endcase
    return h;
  endfunction

  // Next-state logic for counters, pins, flags and the bus slave
  always_comb begin
    logic        tick_p;
    logic        a_ev;
    logic        b_ev;
    logic        slow_ev;
    logic        capt;
    logic        tick1;
    logic        tick2;
    logic [3:0]  hw_set;
    logic [3:0]  sw_set;
    logic [3:0]  sw_clr;
    logic        do_wr;
    logic [31:0] old;
    logic [31:0] mw;
    logic [5:0]  ra;
    logic [31:0] rd;
    c_next  = c_reg;
    d_next  = d_reg;
    hw_set  = 4'h0;
    sw_set  = 4'h0;
    sw_clr  = 4'h0;
    old     = `DCT_ZERO32;
    mw      = `DCT_ZERO32;
    rd      = `DCT_ZERO32;
    ra      = s_axi_araddr[5:0];
    tick_p  = 1'b0;
    a_ev    = 1'b0;
    b_ev    = 1'b0;
    slow_ev = 1'b0;
    capt    = 1'b0;
    tick1   = 1'b0;
    tick2   = 1'b0;
    do_wr   = 1'b0;

    // Prescaler divides the system clock by its value plus one
    tick_p = (c_reg.psc_cnt == c_reg.presc);
    c_next.psc_cnt = tick_p ? 5'h00 : c_reg.psc_cnt + `DCT_PSC_ONE;

    // Pin edges per polarity bit; inputs are synchronous already
    a_ev = c_reg.a_edge ? (pin_a_in && !c_reg.pin_a_prev)
                        : (!pin_a_in && c_reg.pin_a_prev);
    b_ev = c_reg.b_edge ? (pin_b_in && !c_reg.pin_b_prev)
                        : (!pin_b_in && c_reg.pin_b_prev);
    c_next.pin_a_prev = pin_a_in;
    c_next.pin_b_prev = pin_b_in;

    // Slow clock may be unrelated to clk, so it is synchronised first
    c_next.slow_s1 = slow_clk_in;
    c_next.slow_s2 = c_reg.slow_s1;
    c_next.slow_s3 = c_reg.slow_s2;
    slow_ev = c_reg.slow_s2 && !c_reg.slow_s3;

    capt  = (c_reg.mode == DCT_MODE_CAPTURE) ||
            (c_reg.mode == DCT_MODE_SINGLE);
    // Pin B drives both counters outside the capture modes
    tick1 = clk_tick(c_reg.clk1, capt, tick_p, b_ev,
                     pin_b_in == c_reg.b_edge, slow_ev);
    tick2 = clk_tick(c_reg.clk2, capt, tick_p, b_ev,
                     pin_b_in == c_reg.b_edge, slow_ev);

    // Primary counter
    if (tick1) begin
      if (d_reg.cnt1 == `DCT_ZERO16) begin
        unique case (c_reg.mode)
          DCT_MODE_PWM: begin
            // Alternate reload sources, starting from reload A
            d_next.cnt1 = c_reg.pwm_sel ? d_reg.crb : d_reg.cra;
            hw_set[c_reg.pwm_sel ? `DCT_SRC_B : `DCT_SRC_A] = 1'b1;
            c_next.pwm_sel = !c_reg.pwm_sel;
          end
          DCT_MODE_CAPTURE: begin
            d_next.cnt1 = `DCT_PRESET;
            hw_set[`DCT_SRC_C] = 1'b1;
          end
          DCT_MODE_DUAL, DCT_MODE_SINGLE: begin
            d_next.cnt1 = d_reg.cra;
            hw_set[`DCT_SRC_A] = 1'b1;
          end
        endcase
        if (c_reg.a_en && c_reg.mode != DCT_MODE_CAPTURE) begin
          c_next.a_level = !c_reg.a_level;
        end
      end else begin
        d_next.cnt1 = d_reg.cnt1 - `DCT_ONE16;
      end
    end
    // A stopped or re-entered PWM always restarts on reload A
    if (c_reg.mode != DCT_MODE_PWM || c_reg.clk1 == DCT_CLK_STOP) begin
      c_next.pwm_sel = 1'b0;
    end

    // Dual capture on the primary counter; preset follows the copy
    if (c_reg.mode == DCT_MODE_CAPTURE) begin
      if (a_ev) begin
        d_next.cra = d_reg.cnt1;
        hw_set[`DCT_SRC_A] = 1'b1;
        if (c_reg.a_en) begin
          d_next.cnt1 = `DCT_PRESET;
        end
      end
      if (b_ev) begin
        d_next.crb = d_reg.cnt1;
        hw_set[`DCT_SRC_B] = 1'b1;
        if (c_reg.b_en) begin
          d_next.cnt1 = `DCT_PRESET;
        end
      end
    end

    // Secondary counter; reloads from reload B only in dual counter mode
    if (tick2) begin
      if (d_reg.cnt2 == `DCT_ZERO16) begin
        d_next.cnt2 = (c_reg.mode == DCT_MODE_DUAL) ? d_reg.crb
                                                    : `DCT_PRESET;
        hw_set[`DCT_SRC_D] = 1'b1;
      end else begin
        d_next.cnt2 = d_reg.cnt2 - `DCT_ONE16;
      end
    end

    // Single capture on the secondary counter
    if (c_reg.mode == DCT_MODE_SINGLE && b_ev) begin
      d_next.crb = d_reg.cnt2;
      hw_set[`DCT_SRC_B] = 1'b1;
      if (c_reg.b_en) begin
        d_next.cnt2 = `DCT_PRESET;
      end
    end

    // Bus: take address and data independently, then write once both held
    if (s_axi_awvalid && c_reg.awready) begin
      c_next.aw_have = 1'b1;
      c_next.awaddr  = s_axi_awaddr[5:0];
    end
    if (s_axi_wvalid && c_reg.wready) begin
      c_next.w_have = 1'b1;
      c_next.wdata  = s_axi_wdata;
      c_next.wstrb  = s_axi_wstrb;
    end
    do_wr = c_reg.aw_have && c_reg.w_have && !c_reg.bvalid;
    if (do_wr) begin
      c_next.aw_have = 1'b0;
      c_next.w_have  = 1'b0;
      c_next.bvalid  = 1'b1;
      c_next.bresp   = addr_hit(c_reg.awaddr) ? `DCT_RESP_OKAY
                                              : `DCT_RESP_SLVERR;
      // Software writes come after hardware so that all but pending clears win
      case (c_reg.awaddr)
        `DCT_OFF_PRESCALER: begin
          old = {27'h0, c_reg.presc};
          mw  = lane_merge(old, c_reg.wdata, c_reg.wstrb);
          c_next.presc = mw[4:0];
        end
        `DCT_OFF_CLOCK_UNIT: begin
          old = {26'h0, c_reg.clk2, c_reg.clk1};
          mw  = lane_merge(old, c_reg.wdata, c_reg.wstrb);
          c_next.clk1 = mw[`DCT_CLK1_LSB +: 3];
          c_next.clk2 = mw[`DCT_CLK2_LSB +: 3];
        end
        `DCT_OFF_PRIMARY: begin
          mw = lane_merge({16'h0, d_reg.cnt1}, c_reg.wdata, c_reg.wstrb);
          d_next.cnt1 = mw[15:0];
        end
        `DCT_OFF_SECONDARY: begin
          mw = lane_merge({16'h0, d_reg.cnt2}, c_reg.wdata, c_reg.wstrb);
          d_next.cnt2 = mw[15:0];
        end
        `DCT_OFF_RELOAD_A: begin
          mw = lane_merge({16'h0, d_reg.cra}, c_reg.wdata, c_reg.wstrb);
          d_next.cra = mw[15:0];
        end
        `DCT_OFF_RELOAD_B: begin
          mw = lane_merge({16'h0, d_reg.crb}, c_reg.wdata, c_reg.wstrb);
          d_next.crb = mw[15:0];
        end
        `DCT_OFF_MODE_CTRL: begin
          old = {25'h0, c_next.a_level, c_reg.b_en, c_reg.a_en,
                 c_reg.b_edge, c_reg.a_edge, c_reg.mode};
          mw  = lane_merge(old, c_reg.wdata, c_reg.wstrb);
          c_next.mode    = mw[`DCT_MODE_LSB +: 2];
          c_next.a_edge  = mw[`DCT_A_EDGE_BIT];
          c_next.b_edge  = mw[`DCT_B_EDGE_BIT];
          c_next.a_en    = mw[`DCT_A_EN_BIT];
          c_next.b_en    = mw[`DCT_B_EN_BIT];
          c_next.a_level = mw[`DCT_A_LEVEL_BIT];
        end
        `DCT_OFF_INT_CTRL: begin
          old = {24'h0, c_reg.ien, c_reg.pend};
          mw  = lane_merge(old, c_reg.wdata, c_reg.wstrb);
          c_next.ien = mw[`DCT_IEN_LSB +: 4];
          sw_set     = mw[`DCT_PEND_LSB +: 4];     // Zeros have no effect
        end
        `DCT_OFF_PEND_CLEAR: begin
          mw = lane_merge(`DCT_ZERO32, c_reg.wdata, c_reg.wstrb);
          sw_clr = mw[`DCT_PEND_LSB +: 4];
        end
        default: begin
          mw = `DCT_ZERO32;
        end
      endcase
    end
    if (c_reg.bvalid && s_axi_bready) begin
      c_next.bvalid = 1'b0;
    end
    c_next.awready = !c_next.aw_have && !c_next.bvalid;
    c_next.wready  = !c_next.w_have && !c_next.bvalid;

    // Pending: a hardware event in the clearing cycle survives the clear
    c_next.pend = (c_reg.pend | hw_set | sw_set) & ~(sw_clr & ~hw_set);

    // Interrupt lines, and the pin A driver enable gated by a_en and mode
    c_next.irq1 = |(c_next.pend[`DCT_SRC_C:`DCT_SRC_A] &
                    c_next.ien[`DCT_SRC_C:`DCT_SRC_A]);
    c_next.irq2 = c_next.pend[`DCT_SRC_D] &&
                  c_next.ien[`DCT_SRC_D];
    c_next.pin_a_oe = c_next.a_en &&
                      (c_next.mode != DCT_MODE_CAPTURE);

    // Read: answer in the cycle after the address is taken
    if (s_axi_arvalid && c_reg.arready) begin
      case (ra)
        `DCT_OFF_PRESCALER:  rd = {27'h0, c_reg.presc};
        `DCT_OFF_CLOCK_UNIT: rd = {26'h0, c_reg.clk2, c_reg.clk1};
        `DCT_OFF_PRIMARY:    rd = {16'h0, d_reg.cnt1};
        `DCT_OFF_SECONDARY:  rd = {16'h0, d_reg.cnt2};
        `DCT_OFF_RELOAD_A:   rd = {16'h0, d_reg.cra};
        `DCT_OFF_RELOAD_B:   rd = {16'h0, d_reg.crb};
        `DCT_OFF_MODE_CTRL:  rd = {25'h0, c_reg.a_level, c_reg.b_en,
                                   c_reg.a_en, c_reg.b_edge,
                                   c_reg.a_edge, c_reg.mode};
        `DCT_OFF_INT_CTRL:   rd = {24'h0, c_reg.ien, c_reg.pend};
        default:             rd = `DCT_ZERO32;   // Clear register reads 0
      endcase
      c_next.rvalid = 1'b1;
      c_next.rdata  = rd;
      c_next.rresp  = addr_hit(ra) ? `DCT_RESP_OKAY : `DCT_RESP_SLVERR;
    end else if (c_reg.rvalid && s_axi_rready) begin
      c_next.rvalid = 1'b0;
    end
    c_next.arready = !c_next.rvalid;
  end

  // Control state; reset stops both counters and clears all control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end

  // Counts and reload values keep their contents through reset
  always_ff @(posedge clk) begin
    d_reg <= d_next;
  end

  // Every output is a flop; unit wiring places these on the request lines
  assign s_axi_awready = c_reg.awready;
  assign s_axi_wready  = c_reg.wready;
  assign s_axi_bvalid  = c_reg.bvalid;
  assign s_axi_bresp   = c_reg.bresp;
  assign s_axi_arready = c_reg.arready;
  assign s_axi_rvalid  = c_reg.rvalid;
  assign s_axi_rresp   = c_reg.rresp;
  assign s_axi_rdata   = c_reg.rdata;
  assign pin_a_out     = c_reg.a_level;
  assign pin_a_oe      = c_reg.pin_a_oe;
  assign irq_line_one  = c_reg.irq1;
  assign irq_line_two  = c_reg.irq2;

endmodule
